/* File: dv/mii_far_end.sv */
// Far-end MAC/PHY model on the external nibble link of one port.
// Assumes link_clk is shared with the device's link side.
`timescale 1ns/1ps
module mii_far_end (
	input wire logic link_clk,
	input wire logic go,
	input wire logic [3:0] ext_txd,
	input wire logic ext_tx_en,
	output logic [3:0] ext_rxd,
	output logic ext_rx_dv
);
	logic [3:0] cnt = 4'h0;
	initial begin
		ext_rxd = 4'ha;
		ext_rx_dv = 1'b0;
	end
	// Frame nibbles while go; idle data flips every cycle so a stale value never matches
	always @(posedge link_clk) begin
		#1;
		ext_rx_dv = go;
		ext_rxd = go ? cnt : ~ext_rxd;
		cnt = cnt + 4'h3;
	end
endmodule

/* File: dv/port_special_ctrl_status_test.sv */
// Self-checking bench for the port special control/status register.
// Assumes PORT_ID 0 and the far-end model in mii_far_end.
`timescale 1ns/1ps
module port_special_ctrl_status_test;
	import port_special_pkg::*;
	logic clk = 0, rst = 1, link_clk = 0, mm_wr = 0, mm_rd = 0, smi_wr = 0, smi_rd = 0, go = 0, fe = 0;
	logic ts = 0, cds = 0, css = 0, an_en = 0, an_s = 0, an_f = 0, b_s = 0, b_f = 0, iso = 0;
	logic [2:0] ms = 3'h0;
	logic [3:0] fab_txd = 4'h0;
	logic [4:0] smi_index = 5'h00;
	logic [8:0] mm_addr = 9'h000;
	logic [15:0] smi_wdata = 16'h0000;
	logic [31:0] mm_wdata = 32'h0, seed = 32'heeac4d19;
	logic [31:0] mm_rdata;
	logic [15:0] smi_rdata;
	logic lb_o, r200, d16, oe, ext_tx_en, eng_rx_dv, ext_rx_dv;
	logic [2:0] sd, im;
	logic [3:0] ext_txd, eng_rxd, ext_rxd;
	bit m_lb, m_tb, m_cd, m_cs;
	int error_cnt = 0, checks = 0;

	always #2 clk = ~clk;
	// Link edges fall on clk falling edges, 2 ns off the rising edges, away from where the bench drives inputs
	always #32 link_clk = ~link_clk;

	port_special_ctrl_status port_special_ctrl_status_inst (.clk(clk), .rst(rst), .mm_addr(mm_addr),
		.mm_wr(mm_wr), .mm_rd(mm_rd), .mm_wdata(mm_wdata), .mm_rdata(mm_rdata), .smi_index(smi_index),
		.smi_wr(smi_wr), .smi_rd(smi_rd), .smi_wdata(smi_wdata), .smi_rdata(smi_rdata),
		.port_interface_select_strap(ms), .turbo_strap(ts), .clock_dir_strap(cds), .clock_strength_strap(css),
		.emulated_autoneg_enable(an_en), .an_speed_100(an_s), .an_full_duplex(an_f), .basic_speed_100(b_s),
		.basic_full_duplex(b_f), .emulated_phy_isolate(iso), .loopback_en(lb_o), .rate_200_active(r200),
		.clk_drive_16ma(d16), .port_reference_clock_pin_oe(oe), .speed_duplex(sd), .interface_mode(im),
		.link_clk(link_clk), .fab_txd(fab_txd), .fab_tx_en(fe), .ext_rxd(ext_rxd), .ext_rx_dv(ext_rx_dv),
		.ext_txd(ext_txd), .ext_tx_en(ext_tx_en), .eng_rxd(eng_rxd), .eng_rx_dv(eng_rx_dv));
	mii_far_end mii_far_end_inst (.link_clk(link_clk), .go(go), .ext_txd(ext_txd), .ext_tx_en(ext_tx_en),
		.ext_rxd(ext_rxd), .ext_rx_dv(ext_rx_dv));

	// --------------------------------------------------------------
	// Model and helpers
	// --------------------------------------------------------------
	function automatic logic [31:0] nxt(logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// Expected word; speed code from autoneg result or basic control bits
	function automatic logic [31:0] exp_reg();
		logic [2:0] s;
		s = an_en ? {an_f, an_s, ~an_s} : {b_f, b_s, ~b_s};
		return {16'h0, ms[2], m_lb, 3'h0, m_tb, ms[1:0], 1'b0, m_cd, m_cs, s, 2'h0};
	endfunction
	task chk(string n, logic [31:0] e, logic [31:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	// One access on either bus; read data is taken one cycle after the read edge
	task acc(input bit s, input bit w, input logic [8:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		#1;
		if (s) begin
			{smi_wr, smi_rd, smi_index, smi_wdata} = {w, !w, a[4:0], d[15:0]};
		end else begin
			{mm_wr, mm_rd, mm_addr, mm_wdata} = {w, !w, a, d};
		end
		@(posedge clk);
		#1;
		{mm_wr, mm_rd, smi_wr, smi_rd} = 4'h0;
		q = s ? {16'h0, smi_rdata} : mm_rdata;
	endtask
	task do_reset(input logic [2:0] m);
		ms = m;
		{ts, cds, css} = seed[2:0];
		rst = 1;
		repeat (16) @(posedge clk);
		#1 rst = 0;
		{m_tb, m_cd, m_cs, m_lb} = {ts, cds, css, 1'b0};
		repeat (5) @(posedge clk);
	endtask
	// Nibble traffic under a given loopback/isolate setting
	task link_run(input bit lb, input bit is);
		logic [31:0] q;
		logic [4:0] ct, cr;
		logic [9:0] pend[$];
		m_lb = lb;
		iso = is;
		// Loops run full duplex only, so no receive-own-transmit setting is owed
		{an_f, b_f} = 2'h3;
		acc(0, 1, PORT0_SPECIAL_OFS, exp_reg(), q);
		go = 1;
		for (int i = 0; i < 12; i++) begin
			@(posedge link_clk);
			pend.push_back({fab_txd, fe, ext_rxd, ext_rx_dv});
			#1;
			{ct, cr} = pend.pop_front();
			if (i > 4) begin
				chk("to engine", lb ? ct : cr, {eng_rxd, eng_rx_dv});
				chk("to port", (lb | is) ? 5'h0 : ct, {ext_txd, ext_tx_en});
			end
			seed = nxt(seed);
			{fab_txd, fe} = seed[4:0];
		end
		go = 0;
	endtask
	task end_sim;
		if (error_cnt == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// --------------------------------------------------------------
	// Main sequence: every strap mode, both buses, then link traffic
	// --------------------------------------------------------------
	initial begin
		logic [31:0] q, w, e;
		bit r;
		for (int m = 0; m < 5; m++) begin
			do_reset(m[2:0]);
			acc(0, 0, PORT0_SPECIAL_OFS, 0, q);
			chk("reset word", exp_reg(), q);
			for (int k = 0; k < 4; k++) begin
				seed = nxt(seed);
				{an_en, an_s, an_f, b_s, b_f} = seed[9:5];
				w = seed | (k < 2 ? 32'h0420 : 32'h0);
				acc(k[0], 1, k[0] ? {4'h0, SPECIAL_SMI_INDEX} : PORT0_SPECIAL_OFS, w, q);
				{m_lb, m_tb, m_cd, m_cs} = {w[14], w[10], w[6], w[5]};
				repeat (2) @(posedge clk);
				#1;
				e = exp_reg();
				r = m_tb && ms == 3'h1 && (an_en ? an_s : b_s);
				chk("status", {m_cd, m_cs & (ms == 3'h2 || ms == 3'h3 || r), r, m_lb, e[4:2], ms},
					{oe, d16, r200, lb_o, sd, im});
				acc(!k[0], 0, k[0] ? PORT0_SPECIAL_OFS : {4'h0, SPECIAL_SMI_INDEX}, 0, q);
				chk("read word", e, q);
			end
		end
		acc(0, 1, PORT1_SPECIAL_OFS, {16'h0, ~exp_reg()}, q);
		acc(0, 0, PORT1_SPECIAL_OFS, 0, q);
		chk("unmapped", 0, q);
		acc(1, 0, 9'h01e, 0, q);
		chk("unmapped index", {31'h0, m_lb}, {q[31:1], lb_o});
		acc(1, 0, {4'h0, SPECIAL_SMI_INDEX}, 0, q);
		chk("after stray write", exp_reg(), q);
		for (int k = 0; k < 4; k++) link_run(k[1], k[0]);
		end_sim;
	end
	initial begin
		#200000;
		error_cnt++;
		end_sim;
	end
endmodule

/* File: verilog/level_sync.sv */
// Two-stage level synchroniser for a bundle of quasi-static bits.
// Assumes each bit changes rarely; multi-bit values are not coherent.
`timescale 1ns/1ps
module level_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_r;

	// First stage feeds only the second stage
	always_ff @(posedge clk) begin
		meta_r <= d;
		q <= meta_r;
	end
endmodule

/* File: verilog/port_special_ctrl_status.sv */
// Per-port special control/status register with link-side loopback steering.
// Assumes register ports and basic-control inputs are on clk; MII data on link_clk.
`timescale 1ns/1ps

// Overview of operation
// - Loopback bit returns fabric transmits to engine, blocks external port; resets zero.
// - Loopback works even while emulated PHY isolate is asserted.
// - Double-rate bit turns the 100 Mbps rate into 200 Mbps.
// - Double rate only in MII PHY mode; RMII stays 100/10, MAC follows PHY.
// - Strength bit picks 12 or 16 mA in RMII and 200 Mbps; else 12 mA.
// - Clock direction bit makes reference clock pin input at 0, output at 1.
// - Word at 0x1dc port 0, 0x0dc port 1; serial index 31, 16 bits.
// - Bits 31..16 read zero; serial access sees low 16 bits only.
// - Speed/duplex shows autoneg result when enabled, else basic control bits.
module port_special_ctrl_status
	import port_special_pkg::*;
#(
	parameter bit PORT_ID = 1'b0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [8:0] mm_addr,
	input wire logic mm_wr,
	input wire logic mm_rd,
	input wire logic [31:0] mm_wdata,
	output logic [31:0] mm_rdata,
	input wire logic [4:0] smi_index,
	input wire logic smi_wr,
	input wire logic smi_rd,
	input wire logic [15:0] smi_wdata,
	output logic [15:0] smi_rdata,
	input wire logic [2:0] port_interface_select_strap,
	input wire logic turbo_strap,
	input wire logic clock_dir_strap,
	input wire logic clock_strength_strap,
	input wire logic emulated_autoneg_enable,
	input wire logic an_speed_100,
	input wire logic an_full_duplex,
	input wire logic basic_speed_100,
	input wire logic basic_full_duplex,
	input wire logic emulated_phy_isolate,
	output logic loopback_en,
	output logic rate_200_active,
	output logic clk_drive_16ma,
	output logic port_reference_clock_pin_oe,
	output logic [2:0] speed_duplex,
	output logic [2:0] interface_mode,
	input wire logic link_clk,
	input wire logic [3:0] fab_txd,
	input wire logic fab_tx_en,
	input wire logic [3:0] ext_rxd,
	input wire logic ext_rx_dv,
	output logic [3:0] ext_txd,
	output logic ext_tx_en,
	output logic [3:0] eng_rxd,
	output logic eng_rx_dv
);
	import port_special_pkg::*;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [2:0] spd_code(input logic full, input logic fast);
		spd_code = full ? (fast ? SPD_100_FULL : SPD_10_FULL) : (fast ? SPD_100_HALF : SPD_10_HALF);
	endfunction

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic loop_r;
	logic turbo_r;
	logic clkdir_r;
	logic strength_r;
	logic [2:0] mode_r;
	logic [1:0] settle_r;
	logic straps_done_r;
	logic [5:0] strap_s;

	// Straps are pins, so they pass two flops before use
	level_sync #(.WIDTH(6)) u_strap_sync (
		.clk(clk),
		.d({port_interface_select_strap, turbo_strap, clock_dir_strap, clock_strength_strap}),
		.q(strap_s)
	);

	// Address decode and write data selection; memory map wins a tie
	wire [8:0] own_ofs = PORT_ID ? PORT1_SPECIAL_OFS : PORT0_SPECIAL_OFS;
	wire mm_hit = (mm_addr == own_ofs);
	wire smi_hit = (smi_index == SPECIAL_SMI_INDEX);
	wire mm_we = mm_wr && mm_hit;
	wire smi_we = smi_wr && smi_hit;
	wire [15:0] wr16 = mm_we ? mm_wdata[15:0] : smi_wdata;
	wire any_we = mm_we || smi_we;
	wire strap_load = !straps_done_r && (settle_r == STRAP_SETTLE_CYC);

	// Straps are caught after release, once the synchroniser has settled
	always_ff @(posedge clk) begin
		if (rst) begin
			settle_r <= 2'h0;
			straps_done_r <= 1'b0;
		end else begin
			if (!straps_done_r)
				settle_r <= settle_r + 2'h1;
			if (strap_load)
				straps_done_r <= 1'b1;
		end
	end

	// Writable fields; the mode field has no write path
	always_ff @(posedge clk) begin
		if (rst) begin
			loop_r <= LOOPBACK_RST;
			turbo_r <= 1'b0;
			clkdir_r <= 1'b0;
			strength_r <= 1'b0;
			mode_r <= MODE_MII_MAC;
		end else if (strap_load) begin
			mode_r <= strap_s[5:3];
			turbo_r <= strap_s[2];
			clkdir_r <= strap_s[1];
			strength_r <= strap_s[0];
		end else if (any_we) begin
			loop_r <= wr16[LOOPBACK_BIT];
			turbo_r <= wr16[TURBO_BIT];
			clkdir_r <= wr16[CLKDIR_BIT];
			strength_r <= wr16[STRENGTH_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Derived status and control
	// ----------------------------------------------------------------
	wire is_mii_phy = (mode_r == MODE_MII_PHY);
	wire is_rmii = (mode_r == MODE_RMII_A) || (mode_r == MODE_RMII_B);
	wire fast_sel = emulated_autoneg_enable ? an_speed_100 : basic_speed_100;
	wire [2:0] spd_nxt = emulated_autoneg_enable ? spd_code(an_full_duplex, an_speed_100)
		: spd_code(basic_full_duplex, basic_speed_100);
	wire rate200_nxt = turbo_r && is_mii_phy && fast_sel;
	wire drive16_nxt = strength_r && (is_rmii || rate200_nxt);
	wire [15:0] rd16 = {mode_r[2], loop_r, 3'h0, turbo_r, mode_r[1:0], 1'b0, clkdir_r, strength_r,
		speed_duplex, 2'h0};

	// Registered control outputs so pads see clean levels
	always_ff @(posedge clk) begin
		if (rst) begin
			rate_200_active <= 1'b0;
			clk_drive_16ma <= 1'b0;
			port_reference_clock_pin_oe <= 1'b0;
			speed_duplex <= SPD_10_HALF;
		end else begin
			rate_200_active <= rate200_nxt;
			clk_drive_16ma <= drive16_nxt;
			port_reference_clock_pin_oe <= clkdir_r;
			speed_duplex <= spd_nxt;
		end
	end

	assign loopback_en = loop_r;
	assign interface_mode = mode_r;

	// Read answers one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clk) begin
		if (rst) begin
			mm_rdata <= 32'h0;
			smi_rdata <= 16'h0;
		end else begin
			mm_rdata <= (mm_rd && mm_hit) ? {RSVD_UPPER, rd16} : 32'h0;
			smi_rdata <= (smi_rd && smi_hit) ? rd16 : 16'h0;
		end
	end

	// ----------------------------------------------------------------
	// Link domain
	// ----------------------------------------------------------------
	logic [2:0] link_s;
	wire link_rst = link_s[2];
	wire loop_l = link_s[1];
	wire iso_l = link_s[0];

	// Loopback, isolate and reset cross as levels; a nibble may tear at the switch
	level_sync #(.WIDTH(3)) u_link_sync (
		.clk(link_clk),
		.d({rst, loop_r, emulated_phy_isolate}),
		.q(link_s)
	);

	// Steering: loopback ignores isolate, so it keeps working while isolated
	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			ext_txd <= 4'h0;
			ext_tx_en <= 1'b0;
			eng_rxd <= 4'h0;
			eng_rx_dv <= 1'b0;
		end else begin
			ext_txd <= (loop_l || iso_l) ? 4'h0 : fab_txd;
			ext_tx_en <= (loop_l || iso_l) ? 1'b0 : fab_tx_en;
			eng_rxd <= loop_l ? fab_txd : ext_rxd;
			eng_rx_dv <= loop_l ? fab_tx_en : ext_rx_dv;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Two clock domains here, so every property names its own clock and reset
	sequence seq_loop_tx;
		loop_l && fab_tx_en;
	endsequence

	sequence seq_refclk_write;
		mm_we && mm_wdata[CLKDIR_BIT] && !strap_load;
	endsequence

	AST_LOOP_BLOCKS_EXT: assert property (@(posedge link_clk) disable iff (link_rst)
		seq_loop_tx |=> !ext_tx_en && eng_rx_dv)
		else $error("looped transmit leaked to external port");
	AST_LOOP_RESET_ZERO: assert property (@(posedge clk) disable iff (rst)
		$fell(rst) |-> !loopback_en)
		else $error("loopback not zero after reset");
	AST_LOOP_UNDER_ISOLATE: assert property (@(posedge link_clk) disable iff (link_rst)
		seq_loop_tx and iso_l |=> eng_rx_dv && (eng_rxd == $past(fab_txd)))
		else $error("loopback lost while isolated");
	AST_TURBO_ON: assert property (@(posedge clk) disable iff (rst)
		turbo_r && is_mii_phy && fast_sel |=> rate_200_active)
		else $error("double rate not active");
	AST_TURBO_MODE_ONLY: assert property (@(posedge clk) disable iff (rst)
		!is_mii_phy |=> !rate_200_active)
		else $error("double rate outside MII PHY mode");
	AST_DRIVE_FIXED: assert property (@(posedge clk) disable iff (rst)
		is_mii_phy && !rate200_nxt |=> !clk_drive_16ma)
		else $error("drive not 12 mA at 100/10 MII PHY");
	AST_REFCLK_DIR: assert property (@(posedge clk) disable iff (rst)
		seq_refclk_write |=> ##1 port_reference_clock_pin_oe)
		else $error("reference clock pin not output");
	AST_UNMAPPED_ZERO: assert property (@(posedge clk) disable iff (rst)
		mm_rd && !mm_hit |=> mm_rdata == 32'h0)
		else $error("unmapped read not zero");
	AST_UPPER_ZERO: assert property (@(posedge clk) disable iff (rst)
		mm_rd && mm_hit |=> mm_rdata[31:16] == 16'h0 && mm_rdata[LOOPBACK_BIT] == $past(loop_r))
		else $error("reserved upper half not zero");
	AST_SPD_BASIC: assert property (@(posedge clk) disable iff (rst)
		!emulated_autoneg_enable && basic_full_duplex && !basic_speed_100 |=> speed_duplex == SPD_10_FULL)
		else $error("speed/duplex does not follow basic control");
	AST_MODE_RO: assert property (@(posedge clk) disable iff (rst)
		straps_done_r |=> $stable(interface_mode))
		else $error("mode field changed after straps");
endmodule

/* File: verilog/port_special_pkg.sv */
// Constants for the per-port interface special control/status register.
// Assumes one register instance per external port; straps are static pins.
package port_special_pkg;
	// ----------------------------------------------------------------
	// Register placement
	// ----------------------------------------------------------------
	localparam logic [8:0] PORT0_SPECIAL_OFS = 9'h1dc;
	localparam logic [8:0] PORT1_SPECIAL_OFS = 9'h0dc;
	localparam logic [4:0] SPECIAL_SMI_INDEX = 5'h1f;
	localparam logic [15:0] RSVD_UPPER = 16'h0000;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int MODE_HI_BIT = 15;
	localparam int LOOPBACK_BIT = 14;
	localparam int TURBO_BIT = 10;
	localparam int MODE_LO_MSB = 9;
	localparam int MODE_LO_LSB = 8;
	localparam int CLKDIR_BIT = 6;
	localparam int STRENGTH_BIT = 5;
	localparam int SPD_MSB = 4;
	localparam int SPD_LSB = 2;

	// ----------------------------------------------------------------
	// Reset values and timing
	// ----------------------------------------------------------------
	localparam logic LOOPBACK_RST = 1'b0;
	localparam logic [1:0] STRAP_SETTLE_CYC = 2'h3;

	// ----------------------------------------------------------------
	// Interface modes and speed/duplex codes
	// ----------------------------------------------------------------
	localparam logic [2:0] MODE_MII_MAC = 3'h0;
	localparam logic [2:0] MODE_MII_PHY = 3'h1;
	localparam logic [2:0] MODE_RMII_A = 3'h2;
	localparam logic [2:0] MODE_RMII_B = 3'h3;
	localparam logic [2:0] SPD_10_HALF = 3'h1;
	localparam logic [2:0] SPD_100_HALF = 3'h2;
	localparam logic [2:0] SPD_10_FULL = 3'h5;
	localparam logic [2:0] SPD_100_FULL = 3'h6;
endpackage
